// *** sar_adc_conversion_control.v ***
/*
  Conversion control of a 10-bit successive-approximation converter with an
  AXI4-Lite register slave, prescaler, sequencer and result read-order lock.
  Assumes the analog core delivers its result word on sar_result_i, and that
  trigger sources and the sleep indication are synchronous to ref_clk_i.
*/
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
// How it works
// (R1) Result is 10 bits over two bytes, right-justified unless left adjust is set.
// (R2) Reading the low byte locks result updates until the high byte is read; here a written result locks and a result-word read unlocks.
// (R3) Completion flag still sets when a locked result is discarded.
// (R4) Start bit begins conversion, reads one while busy, cleared at single-mode end.
// (R5) Channel change mid-conversion applies only after the current one ends.
// (R6) Trigger rising edge resets the prescaler and starts a conversion.
// (R7) Trigger held high at end, or edges while busy, start nothing.
// (R8) Trigger flags set regardless; software clears them before the next event.
// (R9) Completion flag as trigger runs free; first conversion needs a start write.
// (R10) Nothing converts and selections are ignored until enable is set.
// (R11) Prescaler counts while enabled and is held in reset while disabled.
// (R12) A start-bit write begins on the next converter clock rising edge.
// (R13) Normal conversion 13 converter cycles, first after enable 25.
// (R14) Sample-and-hold at 1.5 cycles normally, 13.5 on the first conversion.
// (R15) At end write result and set flag together; single mode clears start.
// (R16) Auto-triggered sample-and-hold two converter cycles after the trigger edge.
// (R17) Software keeps converter clock between 50 and 200 kHz.
// (R18) Channel code 1111 selects the temperature sensor.
// (R19) Channel field chooses single-ended or differential inputs and gain.
// (R20) Three-bit reference field chooses the conversion reference.
// (R21) Selections track writes until start, freeze, resume in the last cycle.
// (R22) Sleep in single mode with enable starts a conversion once halted.
// (R23) Prescaler divides the system clock by a factor from the divider field.
`timescale 1ns/1ns
`include "sar_ctl_defines.vh"

module sar_adc_conversion_control #(
  parameter TRIG_W = 8
) (
  input wire ref_clk_i, // System clock, 125 MHz
  input wire rst_n_i, // Asynchronous reset, active low
  input wire clk_en_i, // Freezes all state while low
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [TRIG_W-1:0] trig_flags_i, // Trigger source flags, index 0 unused
  input wire cpu_halted_sleep_i, // Processor halted in idle or noise-reduction sleep
  input wire [9:0] sar_result_i, // Analog core result word
  output reg [3:0] input_channel_select_o, // Frozen channel selection to the mux
  output reg [2:0] reference_select_field_o, // Frozen reference selection
  output reg temp_sensor_sel_o, // Temperature sensor routed to the converter
  output reg converter_on_o, // Analog core powered
  output reg sample_hold_o, // One-cycle sample-and-hold strobe
  output reg busy_o // Conversion in progress
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [3:0] chsel_r;
  reg left_adjust_select_r;
  reg [2:0] refsel_r;
  reg converter_enable_bit_r;
  reg start_conversion_bit_r;
  reg auto_trigger_enable_r;
  reg conversion_complete_flag_r;
  reg [2:0] clock_divider_select_r;
  reg [2:0] trigger_source_select_r;
  reg [9:0] result_r;
  reg lock_r;
  reg first_r;
  reg [2:0] state_r;
  reg [7:0] pre_r;
  reg [5:0] half_r;
  reg [5:0] sh_half_r;
  reg [4:0] total_r;
  reg trig_d_r;
  reg sleep_d_r;
  reg aw_hold_r;
  reg w_hold_r;
  reg [11:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // Divide factor 2^(sel+1); the encoding is a free choice of this block
  function [7:0] div_mask;
    input [2:0] sel;
    begin
      div_mask = (8'h02 << sel) - 8'h01;
    end
  endfunction

  function [7:0] lane;
    input [31:0] d;
    input [3:0] s;
    input [7:0] old;
    begin
      lane = s[0] ? d[7:0] : old;
    end
  endfunction

  wire [7:0] mask = div_mask(clock_divider_select_r);
  // Half-cycle ticks at the midpoint and end of each converter clock period
  wire tick_full = converter_enable_bit_r && ((pre_r & mask) == mask); // (R23)
  wire tick_half = converter_enable_bit_r && ((pre_r & mask) == (mask >> 1));
  wire tick = tick_full | tick_half;

  wire trig_sel = trig_flags_i[trigger_source_select_r];
  wire free_run = auto_trigger_enable_r && (trigger_source_select_r == `TS_FREE);
  wire trig_edge = auto_trigger_enable_r && !free_run && trig_sel && !trig_d_r;
  wire sleep_start = cpu_halted_sleep_i && !sleep_d_r && !auto_trigger_enable_r;

  wire [15:0] res_adj = left_adjust_select_r ? {result_r, 6'h00} : {6'h00, result_r}; // (R1)

  // Handshake: each address and data beat is captured on its own, response after both
  assign s_axi_awready = clk_en_i && !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = clk_en_i && !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = clk_en_i && !s_axi_rvalid;

  wire aw_ok = aw_hold_r || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_hold_r || (s_axi_wvalid && s_axi_wready);
  wire [11:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
  wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb;
  wire wr_fire = aw_ok && w_ok && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire wr_csa = wr_fire && (wa == `OFS_CSA) && ws[0];
  wire wr_chref = wr_fire && (wa == `OFS_CHREF) && ws[0];
  wire wr_csb = wr_fire && (wa == `OFS_CSB) && ws[0];
  wire rd_res = rd_fire && (s_axi_araddr == `OFS_RES);
  wire wr_known = (wa == `OFS_CHREF) || (wa == `OFS_CSA) || (wa == `OFS_CSB) ||
                  (wa == `OFS_RES) || (wa == `OFS_SAMP);
  wire [7:0] csa_new = lane(wd, ws, 8'h00);
  wire start_write = wr_csa && csa_new[`CSA_SC];

  wire conv_end = (state_r == ST_CONV) && tick_full && (total_r == 5'd1);
  wire last_cycle = (state_r == ST_CONV) && (total_r == 5'd1);

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else if (clk_en_i)
    begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_CHREF: s_axi_rdata <= {23'h000000, refsel_r, 1'b0, left_adjust_select_r,
                                      chsel_r};
          `OFS_CSA: s_axi_rdata <= {24'h000000, converter_enable_bit_r,
                                    start_conversion_bit_r | busy_o, // (R4)
                                    auto_trigger_enable_r, conversion_complete_flag_r,
                                    1'b0, clock_divider_select_r};
          `OFS_CSB: s_axi_rdata <= {29'h00000000, trigger_source_select_r};
          `OFS_RES: s_axi_rdata <= {16'h0000, res_adj};
          `OFS_SAMP: s_axi_rdata <= {26'h0000000, half_r};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chsel_r <= 4'h0;
      left_adjust_select_r <= 1'b0;
      refsel_r <= 3'h0;
      converter_enable_bit_r <= 1'b0;
      start_conversion_bit_r <= 1'b0;
      auto_trigger_enable_r <= 1'b0;
      conversion_complete_flag_r <= 1'b0;
      clock_divider_select_r <= 3'h0;
      trigger_source_select_r <= 3'h0;
      result_r <= 10'h000;
      lock_r <= 1'b0;
      first_r <= 1'b1;
      state_r <= ST_IDLE;
      pre_r <= 8'h00;
      half_r <= 6'h00;
      sh_half_r <= 6'h00;
      total_r <= 5'h00;
      trig_d_r <= 1'b0;
      sleep_d_r <= 1'b0;
      input_channel_select_o <= 4'h0;
      reference_select_field_o <= 3'h0;
      temp_sensor_sel_o <= 1'b0;
      converter_on_o <= 1'b0;
      sample_hold_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      trig_d_r <= trig_sel;
      sleep_d_r <= cpu_halted_sleep_i;
      sample_hold_o <= 1'b0;
      converter_on_o <= converter_enable_bit_r;
      if (wr_chref)
      begin
        chsel_r <= csa_new[`CHREF_CH_LO +: `CHREF_CH_W];
        left_adjust_select_r <= csa_new[`CHREF_LAR];
        refsel_r <= {wd[8], csa_new[7:6]};
      end
      if (wr_csb)
        trigger_source_select_r <= csa_new[`CSB_TS_LO +: `CSB_TS_W];
      if (wr_csa)
      begin
        converter_enable_bit_r <= csa_new[`CSA_EN];
        auto_trigger_enable_r <= csa_new[`CSA_ATE];
        clock_divider_select_r <= csa_new[`CSA_PS_LO +: `CSA_PS_W];
        if (csa_new[`CSA_SC] && csa_new[`CSA_EN])
          start_conversion_bit_r <= 1'b1;
        if (!csa_new[`CSA_EN])
          first_r <= 1'b1;
      end
      // Write-one clears the flag, but a completion in the same cycle wins
      if (conv_end)
        conversion_complete_flag_r <= 1'b1; // (R3)
      else if (wr_csa && csa_new[`CSA_IF])
        conversion_complete_flag_r <= 1'b0;
      // Low byte and high byte share one word here, so a written result sets the lock
      // and a full-word read clears it; byte reads through strobes are not possible on reads
      if (rd_res)
        lock_r <= 1'b0; // (R2)
      // Prescaler held in reset while disabled or on a trigger edge while idle
      if (!converter_enable_bit_r)
        pre_r <= 8'h00; // (R11)
      else if (trig_edge && state_r == ST_IDLE)
        pre_r <= 8'h00; // (R6)
      else
        pre_r <= pre_r + 8'h01;
      // Selections follow the registers while enabled, except while a conversion holds them
      if (converter_enable_bit_r && (state_r != ST_CONV || last_cycle))
      begin
        input_channel_select_o <= chsel_r; // (R5) (R21)
        reference_select_field_o <= refsel_r; // (R10) (R20)
        temp_sensor_sel_o <= (chsel_r == `CH_TEMP); // (R18) (R19)
      end
      if (!converter_enable_bit_r)
      begin
        state_r <= ST_IDLE; // (R10)
        busy_o <= 1'b0;
        start_conversion_bit_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            // Edges while busy never reach here, so they are dropped
            if (trig_edge)
            begin
              state_r <= ST_CONV; // (R6) (R7) (R8)
              busy_o <= 1'b1;
              half_r <= 6'h00;
              sh_half_r <= `SH_AUTO_HALF; // (R16)
              total_r <= first_r ? `CYC_FIRST : `CYC_NORMAL;
            end
            else if (start_conversion_bit_r || start_write || sleep_start)
            begin
              state_r <= ST_WAIT; // (R12) (R22)
              start_conversion_bit_r <= 1'b1;
              busy_o <= 1'b1;
            end
          end
          ST_WAIT:
          begin
            if (tick_full)
            begin
              state_r <= ST_CONV;
              half_r <= 6'h00;
              sh_half_r <= first_r ? `SH_FIRST_HALF : `SH_NORMAL_HALF; // (R14)
              total_r <= first_r ? `CYC_FIRST : `CYC_NORMAL; // (R13)
            end
          end
          ST_CONV:
          begin
            if (tick)
            begin
              half_r <= half_r + 6'h01;
              if (half_r + 6'h01 == sh_half_r)
                sample_hold_o <= 1'b1;
            end
            if (tick_full)
              total_r <= total_r - 5'd1;
            if (conv_end)
            begin
              first_r <= 1'b0;
              if (!lock_r)
              begin
                result_r <= sar_result_i; // (R15)
                lock_r <= 1'b1;
              end
              if (free_run)
              begin
                // Back to back with the start bit left high
                half_r <= 6'h00; // (R9)
                sh_half_r <= `SH_NORMAL_HALF;
                total_r <= `CYC_NORMAL;
              end
              else
              begin
                state_r <= ST_IDLE;
                busy_o <= 1'b0;
                start_conversion_bit_r <= 1'b0; // (R4) (R15)
              end
            end
          end
          default:
          begin
            state_r <= ST_IDLE;
            busy_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** sar_core_model.sv ***
/*
  Behavioural analog core: holds the level taken at each sample strobe.
  Assumes the bench sets level_i before a conversion samples it.
*/
`timescale 1ns/1ns
module sar_core_model (
  input wire ref_clk_i, // System clock
  input wire rst_n_i, // Reset, active low
  input wire sample_hold_i, // Sample strobe from the control block
  input wire [9:0] level_i, // Input level to convert
  output reg [9:0] result_o // Held conversion result
);
  reg taken_r;
  // No value before the first sample, so show a toggling pattern, not a stale one
  always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      result_o <= 10'h155;
      taken_r <= 1'b0;
    end
    else if (sample_hold_i)
    begin
      result_o <= level_i;
      taken_r <= 1'b1;
    end
    else if (!taken_r)
      result_o <= ~result_o;
endmodule

// *** sar_ctl_defines.vh ***
/*
  Constants for the converter control block: register offsets, field
  positions, response codes and timing counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SAR_CTL_DEFINES_VH
`define SAR_CTL_DEFINES_VH

`define OFS_CHREF 12'h000
`define OFS_CSA 12'h004
`define OFS_CSB 12'h008
`define OFS_RES 12'h00c
`define OFS_SAMP 12'h010

`define CSA_EN 7
`define CSA_SC 6
`define CSA_ATE 5
`define CSA_IF 4
`define CSA_PS_LO 0
`define CSA_PS_W 3

`define CHREF_CH_LO 0
`define CHREF_CH_W 4
`define CHREF_LAR 5
`define CHREF_REF_LO 6
`define CHREF_REF_W 3

`define CSB_TS_LO 0
`define CSB_TS_W 3
`define TS_FREE 3'h0

`define CH_TEMP 4'hf

`define CYC_NORMAL 5'd13
`define CYC_FIRST 5'd25
`define SH_NORMAL_HALF 6'd3
`define SH_FIRST_HALF 6'd27
`define SH_AUTO_HALF 6'd4

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** sar_ctl_monitor.sv ***
/*
  Checker for the converter control block, bound to its top module.
  Assumes one clock domain; clk_en_i low freezes every registered output.
*/
`timescale 1ns/1ns
module sar_ctl_monitor (
  input wire ref_clk_i, // System clock
  input wire rst_n_i, // Reset, active low
  input wire clk_en_i, // Clock enable
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [3:0] input_channel_select_o, // Channel to the mux
  input wire [2:0] reference_select_field_o, // Reference selection
  input wire temp_sensor_sel_o, // Temperature sensor routed
  input wire converter_on_o, // Analog core powered
  input wire sample_hold_o, // Sample strobe
  input wire busy_o // Conversion in progress
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  // Frozen cycles carry no information, so they are left out
  default disable iff (!rst_n_i || !clk_en_i);
  temp_route_a: assert property (temp_sensor_sel_o == (input_channel_select_o == 4'hf))
    else $error("temperature route disagrees with channel");
  sample_busy_a: assert property (sample_hold_o |-> busy_o)
    else $error("sample strobe outside a conversion");
  sample_pulse_a: assert property (sample_hold_o |=> !sample_hold_o)
    else $error("sample strobe longer than one cycle");
  sample_late_a: assert property ($rose(busy_o) |-> !sample_hold_o ##1 !sample_hold_o)
    else $error("sample strobe too early");
  off_idle_a: assert property (!converter_on_o ##1 !converter_on_o |-> !busy_o)
    else $error("conversion while converter is off");
  sel_frozen_a: assert property (sample_hold_o |=>
    $stable({input_channel_select_o, reference_select_field_o}) [*4])
    else $error("selection moved during conversion");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  cover property ($fell(busy_o));
  cover property (sample_hold_o);
  cover property ($rose(temp_sensor_sel_o));
endmodule

bind sar_adc_conversion_control sar_ctl_monitor mon_u (.*);

// *** tb_sar_adc_conversion_control.sv ***
/*
  Self-checking bench for the converter control block over its register bus.
  Assumes divider field n gives 2^(n+1) system clocks per converter clock.
*/
`timescale 1ns/1ns
`include "sar_ctl_defines.vh"
module tb_sar_adc_conversion_control;
  reg ref_clk_i, rst_n_i, clk_en_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready, cpu_halted_sleep_i, busy_q, trig_q;
  reg [11:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd_d;
  reg [3:0] s_axi_wstrb;
  reg [7:0] trig_flags_i;
  reg [9:0] level;
  reg [1:0] rresp_d, bresp_d;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [9:0] sar_result_i;
  wire [3:0] input_channel_select_o;
  wire [2:0] reference_select_field_o;
  wire temp_sensor_sel_o, converter_on_o, sample_hold_o, busy_o;
  integer failures, checks, cyc, n_rise, n_sh, t_rise, t_sh, t_fall, t_trig, base;

  sar_adc_conversion_control dut_u (.*);
  sar_core_model core_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sample_hold_i(sample_hold_o), .level_i(level), .result_o(sar_result_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task print_verdict;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task rng(input integer v, input integer lo, input integer hi);
  begin
    checks = checks + 1;
    if (v < lo || v > hi)
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  end
  endtask

  task wr(input [11:0] a, input [31:0] d);
  begin
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bresp_d = s_axi_bresp;
    s_axi_bready <= 1'b0;
  end
  endtask

  task rd(input [11:0] a, output [31:0] d);
  begin
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    s_axi_rready <= 1'b0;
  end
  endtask

  task wait_done;
  begin
    @(posedge ref_clk_i);
    wait (busy_o === 1'b0);
    // Two edges, so the event recorder has logged the fall before anyone reads it
    repeat (2) @(posedge ref_clk_i);
  end
  endtask

  // Event times are taken in one process so their differences never race
  always @(posedge ref_clk_i)
  begin
    cyc = cyc + 1;
    if (busy_o === 1'b1 && busy_q === 1'b0)
    begin
      n_rise = n_rise + 1;
      t_rise = cyc;
    end
    if (busy_o === 1'b0 && busy_q === 1'b1)
      t_fall = cyc;
    if (sample_hold_o === 1'b1)
    begin
      n_sh = n_sh + 1;
      t_sh = cyc;
    end
    if (trig_flags_i[1] && !trig_q)
      t_trig = cyc;
    busy_q = busy_o;
    trig_q = trig_flags_i[1];
    if (cyc == 20000)
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t timeout", $time);
      print_verdict;
    end
  end

  initial
  begin
    {failures, checks, cyc, n_rise, n_sh, t_rise, t_sh, t_fall, t_trig} = 0;
    busy_q = 1'b0;
    trig_q = 1'b0;
    rst_n_i <= 1'b0;
    clk_en_i <= 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    s_axi_awaddr <= 12'h0;
    s_axi_araddr <= 12'h0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    trig_flags_i <= 8'h0;
    cpu_halted_sleep_i <= 1'b0;
    level <= 10'h2a5;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(`OFS_CSA, rd_d);
    chk(rd_d, 32'h0);
    rd(12'h014, rd_d);
    chk({rd_d[29:0], rresp_d}, {30'h0, `RESP_SLVERR});
    wr(12'h014, 32'h0);
    chk({30'h0, bresp_d}, {30'h0, `RESP_SLVERR});
    wr(`OFS_CHREF, 32'h5);
    chk({30'h0, bresp_d}, {30'h0, `RESP_OKAY});
    wr(`OFS_CSA, 32'h40);
    repeat (40) @(posedge ref_clk_i);
    chk({27'h0, converter_on_o, input_channel_select_o}, 32'h0);
    chk(n_rise, 32'h0);
    // Divider 0 runs the converter clock far above its accuracy band for short runs
    wr(`OFS_CSA, 32'h80);
    repeat (4) @(posedge ref_clk_i);
    chk({27'h0, converter_on_o, input_channel_select_o}, 32'h15);
    wr(`OFS_CSA, 32'hc0);
    wait_done;
    rng(t_fall - t_rise, 50, 53);
    rng(t_fall - t_sh, 22, 24);
    rd(`OFS_CSA, rd_d);
    chk(rd_d & 32'h50, 32'h10);
    rd(`OFS_RES, rd_d);
    chk(rd_d & 32'hffff, 32'h2a5);
    level <= 10'h15a;
    wr(`OFS_CSA, 32'hc0);
    wr(`OFS_CHREF, 32'h12f);
    rd(`OFS_CSA, rd_d);
    chk(rd_d & 32'h40, 32'h40);
    // Late enough that a selection which kept tracking would already show the new value
    chk({25'h0, reference_select_field_o, input_channel_select_o}, 32'h5);
    wait_done;
    rng(t_fall - t_rise, 26, 29);
    rng(t_fall - t_sh, 22, 24);
    chk({24'h0, reference_select_field_o, temp_sensor_sel_o, input_channel_select_o},
      32'h9f);
    level <= 10'h3ff;
    wr(`OFS_CSA, 32'hd0);
    wait_done;
    rd(`OFS_CSA, rd_d);
    chk(rd_d & 32'h10, 32'h10);
    rd(`OFS_RES, rd_d);
    chk(rd_d & 32'hffff, 32'h5680);
    wr(`OFS_CSB, 32'h1);
    wr(`OFS_CSA, 32'hb0);
    base = n_rise;
    trig_flags_i <= 8'h02;
    repeat (10) @(posedge ref_clk_i);
    rng(t_sh - t_trig, 3, 6);
    trig_flags_i <= 8'h00;
    repeat (2) @(posedge ref_clk_i);
    trig_flags_i <= 8'h02;
    wait_done;
    repeat (30) @(posedge ref_clk_i);
    chk(n_rise - base, 32'h1);
    wr(`OFS_CSB, 32'h0);
    base = n_sh;
    repeat (30) @(posedge ref_clk_i);
    chk(n_sh - base, 32'h0);
    wr(`OFS_CSA, 32'he0);
    repeat (90) @(posedge ref_clk_i);
    rng(n_sh - base, 3, 4);
    rd(`OFS_CSA, rd_d);
    chk(rd_d & 32'h40, 32'h40);
    wr(`OFS_CSA, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    chk({30'h0, converter_on_o, busy_o}, 32'h0);
    wr(`OFS_CSA, 32'h82);
    base = n_rise;
    cpu_halted_sleep_i <= 1'b1;
    repeat (70) @(posedge ref_clk_i);
    chk(n_rise - base, 32'h1);
    // Divider 2 gives eight system clocks per converter clock
    wait_done;
    rng(t_fall - t_rise, 200, 209);
    rng(t_fall - t_sh, 91, 93);
    print_verdict;
  end
endmodule
